// ### common/gdmfsm_regs.vh
// Constants of the gate driver operating-mode state machine
`ifndef GDMFSM_REGS_VH
`define GDMFSM_REGS_VH
`define GDM_MODE_W        3
`define GDM_MODE_DEFAULT  3'h0
`define GDM_MODE_ERROR    3'h1
`define GDM_MODE_CONFIG   3'h2
`define GDM_MODE_CONFIGD  3'h3
`define GDM_MODE_ACTIVE   3'h4
`define GDM_MODE_VERIFY   3'h5
`define GDM_MODE_WEAK     3'h6
`define GDM_LOCK_CYCLES   9'h100
`define GDM_LOCK_W        9
`define GDM_VMTO_CYCLES   16'h1000
`define GDM_VMTO_W        16
`define GDM_ERR_W         6
`define GDM_ERR_DESATURATION_FAULT     0
`define GDM_ERR_OCP       1
`define GDM_ERR_EN        2
`define GDM_ERR_ADC       3
`define GDM_ERR_UVLO      4
`define GDM_ERR_VMTO      5
`endif

// ### logic/gdm_mode_fsm.v
// Operating-mode state machine of the isolated gate driver
`timescale 1ns/10ps
`default_nettype none
`include "gdmfsm_regs.vh"
module gdm_mode_fsm #(
  parameter VMTO_CYCLES = `GDM_VMTO_CYCLES
) (
  input  wire                   sys_clk,
  input  wire                   reset,
  input  wire                   enable_pin,
  input  wire                   pwm_input,
  input  wire                   desaturation_fault,
  input  wire                   overcurrent_fault,
  input  wire                   adc_boundary_fault,
  input  wire                   adc_boundary_en,
  input  wire                   secondary_undervoltage_lockout,
  input  wire                   class_c_event,
  input  wire                   begin_configuration_command,
  input  wire                   exit_configuration_command,
  input  wire                   begin_verification_command,
  input  wire                   clear_sticky_bit,
  input  wire                   output_tristate,
  input  wire                   cfg_write_req,
  output reg  [`GDM_MODE_W-1:0] current_mode_field,
  output reg                    gate_on,
  output reg                    gate_weak_on,
  output reg                    gate_tristate,
  output reg                    safe_turn_off,
  output reg                    regular_turn_off,
  output reg  [`GDM_ERR_W-1:0]  error_sticky,
  output reg                    class_a_fault_pin_n,
  output reg                    class_b_fault_pin_n,
  output reg                    reset_ready_pin,
  output reg                    enabled_state,
  output reg                    active_state,
  output reg                    config_write_ok,
  output reg                    command_error,
  output reg                    reenable_locked
);
  localparam [`GDM_VMTO_W-1:0] VMTO_LIMIT = VMTO_CYCLES[`GDM_VMTO_W-1:0];

  // Pins from the primary side are asynchronous
  wire [6:0] pin_s;
  gdm_sync #(.W(7)) u_sync (
    .sys_clk  (sys_clk),
    .reset    (reset),
    .async_in ({enable_pin, pwm_input, desaturation_fault, overcurrent_fault,
                adc_boundary_fault, secondary_undervoltage_lockout, output_tristate}),
    .sync_out (pin_s)
  );
  wire en_s    = pin_s[6];
  wire pwm_s   = pin_s[5];
  wire desaturation_fault_s = pin_s[4];
  wire ocp_s   = pin_s[3];
  wire adc_s   = pin_s[2];
  wire uvlo_s  = pin_s[1];
  wire tri_s   = pin_s[0];

  reg [`GDM_MODE_W-1:0] mode_q, mode_d;
  reg                   en_prev_q;
  reg                   desaturation_fault_prev_q, ocp_prev_q, adc_prev_q, uvlo_prev_q;
  reg                   pend_cfg_q, pend_cfg_d;
  reg [`GDM_LOCK_W-1:0] lock_q;
  reg [`GDM_VMTO_W-1:0] vmto_q;
  reg                   vmto_run_q;
  reg                   ready_q;

  function is_enabled_mode;
    input [`GDM_MODE_W-1:0] m;
    begin
      is_enabled_mode = (m == `GDM_MODE_ACTIVE) || (m == `GDM_MODE_WEAK);
    end
  endfunction

  // Edge-detected events; a level fault fires once per occurrence
  wire en_rise   = en_s & ~en_prev_q;
  wire en_fall   = ~en_s & en_prev_q;
  wire desaturation_fault_ev  = desaturation_fault_s & ~desaturation_fault_prev_q;
  wire ocp_ev    = ocp_s & ~ocp_prev_q;
  wire adc_ev    = adc_boundary_en & adc_s & ~adc_prev_q;
  wire safe_ev   = desaturation_fault_ev | ocp_ev;
  wire class_a   = safe_ev | en_fall | adc_ev;
  wire vmto_ev   = vmto_run_q && (vmto_q == VMTO_LIMIT - 16'h0001);
  wire uvlo_ev   = uvlo_s & ~uvlo_prev_q;
  wire class_b   = uvlo_ev | vmto_ev;
  wire class_b_cond = uvlo_s;
  wire a_trans   = class_a && ((mode_q == `GDM_MODE_ACTIVE) || (mode_q == `GDM_MODE_WEAK));
  wire b_trans   = class_b && (mode_q != `GDM_MODE_ERROR);
  wire emergency_shutdown_sequence       = class_a | class_b;
  wire locked    = (lock_q != {`GDM_LOCK_W{1'b0}});

  // Next mode; Class B first, then Class A, then commands and enable.
  // Class C events have no path into this decision.
  always @* begin
    mode_d     = mode_q;
    pend_cfg_d = pend_cfg_q;
    if (class_b) begin
      mode_d = `GDM_MODE_ERROR;
      if (begin_configuration_command && mode_q == `GDM_MODE_ERROR)
        pend_cfg_d = 1'b1;
    end else if (class_a) begin
      if (mode_q == `GDM_MODE_ACTIVE)
        mode_d = `GDM_MODE_CONFIGD;
      else if (mode_q == `GDM_MODE_WEAK)
        mode_d = `GDM_MODE_VERIFY;
    end else begin
      case (mode_q)
        `GDM_MODE_DEFAULT: begin
          if (begin_configuration_command)
            mode_d = `GDM_MODE_CONFIG;
        end
        `GDM_MODE_ERROR: begin
          if (begin_configuration_command || pend_cfg_q) begin
            if (class_b_cond)
              pend_cfg_d = 1'b1;
            else begin
              mode_d     = `GDM_MODE_CONFIG;
              pend_cfg_d = 1'b0;
            end
          end else if (clear_sticky_bit && !class_b_cond)
            mode_d = `GDM_MODE_DEFAULT;
        end
        `GDM_MODE_CONFIG: begin
          if (exit_configuration_command)
            mode_d = `GDM_MODE_CONFIGD;
          else if (begin_verification_command)
            mode_d = `GDM_MODE_VERIFY;
        end
        `GDM_MODE_CONFIGD: begin
          if (en_rise && !locked)
            mode_d = `GDM_MODE_ACTIVE;
        end
        `GDM_MODE_VERIFY: begin
          if (en_rise && !locked)
            mode_d = `GDM_MODE_WEAK;
        end
        `GDM_MODE_ACTIVE: mode_d = mode_q;
        `GDM_MODE_WEAK:   mode_d = mode_q;
        default: mode_d = `GDM_MODE_DEFAULT;
      endcase
    end
    if (mode_d != `GDM_MODE_ERROR)
      pend_cfg_d = 1'b0;
  end

  // Illegal commands are reported but never move the mode
  wire cmd_bad = (begin_configuration_command &&
                  !(mode_q == `GDM_MODE_DEFAULT || mode_q == `GDM_MODE_ERROR)) ||
                 ((exit_configuration_command || begin_verification_command) &&
                  mode_q != `GDM_MODE_CONFIG);

  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      mode_q       <= `GDM_MODE_DEFAULT;
      pend_cfg_q   <= 1'b0;
      en_prev_q    <= 1'b0;
      desaturation_fault_prev_q <= 1'b0;
      ocp_prev_q   <= 1'b0;
      adc_prev_q   <= 1'b0;
      uvlo_prev_q  <= 1'b0;
      lock_q       <= `GDM_LOCK_CYCLES;
      vmto_q       <= {`GDM_VMTO_W{1'b0}};
      vmto_run_q   <= 1'b0;
      ready_q      <= 1'b0;
    end else begin
      mode_q       <= mode_d;
      pend_cfg_q   <= pend_cfg_d;
      en_prev_q    <= en_s;
      desaturation_fault_prev_q <= desaturation_fault_s;
      ocp_prev_q   <= ocp_s;
      adc_prev_q   <= adc_s;
      uvlo_prev_q  <= uvlo_s;
      ready_q      <= 1'b1;
      // Reload on every emergency turn-off, so the window restarts
      if (emergency_shutdown_sequence)
        lock_q <= `GDM_LOCK_CYCLES;
      else if (locked)
        lock_q <= lock_q - 9'h001;
      // Not restarted by entering weak active mode
      if (mode_q == `GDM_MODE_CONFIG && mode_d == `GDM_MODE_VERIFY) begin
        vmto_run_q <= 1'b1;
        vmto_q     <= {`GDM_VMTO_W{1'b0}};
      end else if (mode_d != `GDM_MODE_VERIFY && mode_d != `GDM_MODE_WEAK) begin
        vmto_run_q <= 1'b0;
      end else if (vmto_run_q) begin
        vmto_q <= vmto_q + 16'h0001;
      end
    end
  end

  // Registered outputs
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      current_mode_field  <= `GDM_MODE_DEFAULT;
      gate_on             <= 1'b0;
      gate_weak_on        <= 1'b0;
      gate_tristate       <= 1'b0;
      safe_turn_off       <= 1'b0;
      regular_turn_off    <= 1'b0;
      error_sticky        <= {`GDM_ERR_W{1'b0}};
      class_a_fault_pin_n <= 1'b1;
      class_b_fault_pin_n <= 1'b1;
      reset_ready_pin     <= 1'b0;
      enabled_state       <= 1'b0;
      active_state        <= 1'b0;
      config_write_ok     <= 1'b0;
      command_error       <= 1'b0;
      reenable_locked     <= 1'b1;
    end else begin
      current_mode_field  <= mode_d;
      gate_on             <= pwm_s && (mode_d == `GDM_MODE_ACTIVE) && !tri_s;
      gate_weak_on        <= pwm_s && (mode_d == `GDM_MODE_WEAK) && !tri_s;
      gate_tristate       <= tri_s;
      safe_turn_off       <= safe_ev;
      regular_turn_off    <= (class_a && !safe_ev) || class_b;
      // Set wins over clear-sticky in the same cycle
      error_sticky        <= (clear_sticky_bit ? {`GDM_ERR_W{1'b0}} : error_sticky) |
                             {vmto_ev, uvlo_ev, adc_ev, en_fall, ocp_ev, desaturation_fault_ev};
      // Stays low until clear-sticky, in any mode; commands do not release it
      if (a_trans || (adc_ev && mode_q != `GDM_MODE_ACTIVE && mode_q != `GDM_MODE_WEAK))
        class_a_fault_pin_n <= 1'b0;
      else if (clear_sticky_bit)
        class_a_fault_pin_n <= 1'b1;
      if (b_trans)
        class_b_fault_pin_n <= 1'b0;
      else if (clear_sticky_bit)
        class_b_fault_pin_n <= 1'b1;
      reset_ready_pin     <= ready_q;
      enabled_state       <= is_enabled_mode(mode_d);
      active_state        <= (mode_d == `GDM_MODE_ACTIVE);
      // Class A never blocks configuration writes; they are granted only in configuration mode
      config_write_ok     <= cfg_write_req && (mode_q == `GDM_MODE_CONFIG);
      command_error       <= cmd_bad | class_c_event;
      reenable_locked     <= emergency_shutdown_sequence | (lock_q > 9'h001);
    end
  end
endmodule // gdm_mode_fsm
`default_nettype wire

// ### logic/gdm_sync.v
// Two-flop synchroniser for a group of asynchronous pins
`timescale 1ns/10ps
`default_nettype none
module gdm_sync #(
  parameter W = 1
) (
  input  wire         sys_clk,
  input  wire         reset,
  input  wire [W-1:0] async_in,
  output reg  [W-1:0] sync_out
);
  reg [W-1:0] meta_q;
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      meta_q   <= {W{1'b0}};
      sync_out <= {W{1'b0}};
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule // gdm_sync
`default_nettype wire

// ### tb/gdm_fsm_assertions.sv
// Concurrent checks on the mode state machine ports
`timescale 1ns/10ps
`default_nettype none
`include "gdmfsm_regs.vh"
module gdm_fsm_chk (
  input wire logic       sys_clk,
  input wire logic       reset,
  input wire logic [2:0] current_mode_field,
  input wire logic       gate_on,
  input wire logic       gate_weak_on,
  input wire logic       class_a_fault_pin_n,
  input wire logic       class_b_fault_pin_n,
  input wire logic       reset_ready_pin,
  input wire logic       enabled_state,
  input wire logic       active_state,
  input wire logic       reenable_locked,
  input wire logic       adc_boundary_en
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  wire [2:0] m = current_mode_field;
  property p_range; m <= 3'h6; endproperty
  a_range: assert property (p_range) else $error("mode out of range");
  // Output lags the mode by a cycle at most
  property p_on; gate_on |-> m == `GDM_MODE_ACTIVE || $past(m) == `GDM_MODE_ACTIVE; endproperty
  a_on: assert property (p_on) else $error("gate on outside active");
  property p_weak; gate_weak_on |-> m == `GDM_MODE_WEAK || $past(m) == `GDM_MODE_WEAK; endproperty
  a_weak: assert property (p_weak) else $error("weak on outside weak");
  property p_en; enabled_state == (m == 3'h4 || m == 3'h6) && active_state == (m == 3'h4);
  endproperty
  a_en: assert property (p_en) else $error("enabled or active state wrong");
  property p_a; $past(m) == 3'h4 && m != 3'h4 |-> m inside {3'h1, 3'h3}; endproperty
  a_a: assert property (p_a) else $error("bad exit from active");
  property p_cfg; m == 3'h2 && $past(m) != 3'h2 |-> $past(m) inside {3'h0, 3'h1}; endproperty
  a_cfg: assert property (p_cfg) else $error("bad entry to configuration");
  property p_fa; $fell(class_a_fault_pin_n) && !adc_boundary_en |-> $past(m) inside {3'h4, 3'h6};
  endproperty
  a_fa: assert property (p_fa) else $error("fault A without transition");
  property p_fb; $fell(class_b_fault_pin_n) |-> m == 3'h1 && $past(m) != 3'h1; endproperty
  a_fb: assert property (p_fb) else $error("fault B without transition");
  property p_rdy; reset_ready_pin |=> reset_ready_pin; endproperty
  a_rdy: assert property (p_rdy) else $error("ready dropped out of reset");
  property p_lock; m == 3'h4 && $past(m) != 3'h4 |-> !$past(reenable_locked) && $past(m) == 3'h3;
  endproperty
  a_lock: assert property (p_lock) else $error("bad activation");
  c_act: cover property (m == 3'h4);
  c_weak: cover property (m == 3'h6);
  c_fb: cover property ($fell(class_b_fault_pin_n));
endmodule // gdm_fsm_chk
bind gdm_mode_fsm gdm_fsm_chk u_chk (.sys_clk(sys_clk), .reset(reset),
  .current_mode_field(current_mode_field), .gate_on(gate_on), .gate_weak_on(gate_weak_on),
  .class_a_fault_pin_n(class_a_fault_pin_n), .class_b_fault_pin_n(class_b_fault_pin_n),
  .reset_ready_pin(reset_ready_pin), .enabled_state(enabled_state),
  .active_state(active_state), .reenable_locked(reenable_locked),
  .adc_boundary_en(adc_boundary_en));
`default_nettype wire

// ### tb/gdm_host.sv
// Host-side model driving the enable pin
`timescale 1ns/10ps
`default_nettype none
module gdm_host (
  input  wire logic sys_clk,
  input  wire logic go,
  input  wire logic drop,
  output var  logic enable_pin
);
  int n_go = 0;
  int n_seen = 0;
  initial enable_pin = 1'b0;
  always @(posedge go) n_go++;
  // One process owns the pin; a drop only releases it
  // Invalid first, valid only once the lockout is over
  always @(posedge go or posedge drop) begin
    @(posedge sys_clk);
    #2;
    enable_pin = 1'b0;
    if (n_go != n_seen) begin
      n_seen = n_go;
      repeat (260) @(posedge sys_clk);
      #2;
      enable_pin = 1'b1;
    end
  end
endmodule // gdm_host
`default_nettype wire

// ### tb/tb.sv
// Self-checking bench of the operating-mode state machine
`timescale 1ns/10ps
`default_nettype none
module tb;
  localparam int VMTO = 600;
  logic sys_clk = 0, reset = 1, pwm_input = 0, go = 0, drop = 0, sp, rp;
  logic desaturation_fault = 0, overcurrent_fault = 0, class_c_event = 0;
  logic secondary_undervoltage_lockout = 0, cfg_write_req = 0;
  logic [3:0] cmd = 0;
  logic [15:0] lf = 16'hBCED;
  int errors = 0, n_compared = 0, em = 0, cyc = 0, t5 = 0;
  wire enable_pin, gate_on, gate_weak_on, safe_turn_off, regular_turn_off, reset_ready_pin;
  wire class_a_fault_pin_n, class_b_fault_pin_n, enabled_state, active_state, config_write_ok;
  wire command_error;
  wire [2:0] current_mode_field;
  wire [5:0] error_sticky;
  gdm_host host (.sys_clk, .go, .drop, .enable_pin);
  gdm_mode_fsm #(.VMTO_CYCLES(VMTO)) uut (.sys_clk, .reset, .enable_pin, .pwm_input,
    .desaturation_fault, .overcurrent_fault, .adc_boundary_fault(1'b0), .adc_boundary_en(1'b0),
    .secondary_undervoltage_lockout, .class_c_event, .begin_configuration_command(cmd[0]),
    .exit_configuration_command(cmd[1]), .begin_verification_command(cmd[2]),
    .clear_sticky_bit(cmd[3]), .output_tristate(1'b0), .cfg_write_req, .current_mode_field,
    .gate_on, .gate_weak_on, .gate_tristate(), .safe_turn_off, .regular_turn_off, .error_sticky,
    .class_a_fault_pin_n, .class_b_fault_pin_n, .reset_ready_pin, .enabled_state,
    .active_state, .config_write_ok, .command_error, .reenable_locked());
  always #25 sys_clk = ~sys_clk;
  function automatic logic [15:0] lfsr(logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // Command model, without Class B pending
  function automatic int nxt(int m, int c);
    case (c)
      0: return (m < 2) ? 2 : m;
      1: return (m == 2) ? 3 : m;
      2: return (m == 2) ? 5 : m;
      default: return (m == 1) ? 0 : m;
    endcase
  endfunction
  task automatic chk(string s, logic [7:0] e, logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", s, e, g);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask
  task automatic wait_mode(int e);
    int i;
    sp = 0;
    rp = 0;
    for (i = 0; i < 700 && current_mode_field !== e[2:0]; i++) begin
      tick(1);
      sp |= safe_turn_off;
      rp |= regular_turn_off;
    end
    em = e;
    chk("mode", e, current_mode_field);
    chk("state", {e == 4 || e == 6, e == 4}, {enabled_state, active_state});
    if (e != 4 && e != 6) chk("gate", 0, {gate_on, gate_weak_on});
  endtask
  task automatic cmd_go(int c, int e);
    cmd[c] = 1'b1;
    tick(1);
    cmd = 0;
    wait_mode((e < 0) ? nxt(em, c) : e);
  endtask
  task automatic done(string s);
    $display("test %s done", s);
  endtask
  task automatic close_out;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Random PWM keeps the disabled-output check honest
  always @(posedge sys_clk) begin
    #2;
    lf = lfsr(lf);
    pwm_input = lf[0];
    cyc++;
    if (cyc == 6000) begin
      errors++;
      close_out();
    end
  end
  initial begin
    tick(10);
    reset = 0;
    tick(2);
    chk("ready", 1, reset_ready_pin);
    chk("fault_pins", 3, {class_a_fault_pin_n, class_b_fault_pin_n});
    wait_mode(0);
    for (int c = 1; c < 4; c++) cmd_go(c, -1);
    cmd_go(0, -1);
    cfg_write_req = 1;
    tick(1);
    cfg_write_req = 0;
    chk("cfg_ok", 1, config_write_ok);
    cmd_go(1, -1);
    go = 1;
    wait_mode(4);
    done("activate");
    desaturation_fault = 1;
    wait_mode(3);
    chk("safe", 1, sp);
    chk("sticky", 1, error_sticky[0]);
    chk("fault_a", 0, class_a_fault_pin_n);
    desaturation_fault = 0;
    go = 0;
    tick(1);
    go = 1;
    wait_mode(4);
    drop = 1;
    wait_mode(3);
    chk("regular", 1, rp);
    overcurrent_fault = 1;
    class_c_event = 1;
    tick(1);
    class_c_event = 0;
    chk("cmd_err", 1, command_error);
    tick(5);
    overcurrent_fault = 0;
    wait_mode(3);
    done("class_a");
    secondary_undervoltage_lockout = 1;
    wait_mode(1);
    chk("fault_b", 0, class_b_fault_pin_n);
    chk("regular", 1, rp);
    cmd_go(3, 1);
    cmd_go(0, 1);
    secondary_undervoltage_lockout = 0;
    wait_mode(2);
    cmd_go(2, -1);
    t5 = cyc;
    go = 0;
    tick(1);
    go = 1;
    wait_mode(6);
    wait_mode(1);
    chk("timeout", 1, (cyc - t5) >= VMTO - 5 && (cyc - t5) <= VMTO + 10);
    chk("fault_b", 0, class_b_fault_pin_n);
    cmd_go(3, -1);
    chk("sticky", 0, error_sticky);
    done("class_b");
    close_out();
  end
endmodule // tb
`default_nettype wire
